/* hw/pmbus_target_consts.svh */
// Constants for the management serial target
`ifndef PMBUS_TARGET_CONSTS_SVH
`define PMBUS_TARGET_CONSTS_SVH

`define CMD_ON_OFF_CONTROL 8'h01
`define CMD_WRITE_PROTECT 8'h10
`define CMD_VIN_MODE 8'h78
`define CMD_USER_F2 8'hF2
`define CMD_WORD_LO 8'h88
`define CMD_WORD_HI 8'h8E
`define ALERT_RESP_ADDR 7'h0C
`define ALERT_RESP_ADDR8 8'h19
`define ON_OFF_RUN_BIT 7
`define WP_ALL 8'h80
`define WP_RESET 8'h00
`define PROG_OPEN_MS 16
`define PROG_OPEN_CYCLES (`PROG_OPEN_MS * 25000)
`define DIR_WRITE 1'b0
`define DIR_READ 1'b1

`endif

/* hw/pmbus_target_pkg.sv */
// Types for the management serial target
package pmbus_target_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h3,
    ST_RX = 4'h2,
    ST_RX_ACK = 4'h6,
    ST_TX = 4'h7,
    ST_TX_ACK = 4'h5,
    ST_IGNORE = 4'h4
  } bus_state_t;
  typedef enum logic [1:0] {
    MODE_I2C = 2'h0,
    MODE_SMBUS = 2'h1,
    MODE_PMBUS = 2'h2
  } bus_mode_t;
endpackage

/* hw/pec_crc8.sv */
// CRC-8 (x^8+x^2+x+1) update over one byte for packet error checking
`timescale 1ns/1ps
module pec_crc8 (
  // Running value and byte in
  input wire logic [7:0] crc_i,
  input wire logic [7:0] data_i,
  // Updated value
  output logic [7:0] crc_o
);
  always_comb begin
    logic [7:0] c;
    c = crc_i ^ data_i;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    end
    crc_o = c;
  end
endmodule

/* hw/pmbus_target.sv */
// Target-side serial management port with address strap and PEC
`timescale 1ns/1ps
`include "pmbus_target_consts.svh"
// Operation
// - Target address is one of 32 values picked by the strap pin level.
// - 8-bit addresses are even values in 80-8E, C0-CE, E0-EE, F0-FE.
// - Address byte LSB is direction: zero write, one read.
// - 7-bit address is the 8-bit value shifted right, 40 to 7F.
// - Writes to 78h and F2h allowed from about 16ms after reset until enable high.
// - If enable is already high, start soft-start 16ms after reset.
// - Pre-enable window also accepts writes replacing default contents.
// - Reads of 88h to 8Eh return two bytes plus optional PEC.
// - Reads of writable codes like 78h, F2h return one byte plus PEC in SMBus/PMBus.
// - SMBus/PMBus modes provide an alert line and packet error check.
// - PEC byte is optional in SMBus/PMBus and never sent in I2C.
// - SMBus/PMBus answer alert response address 19h with own address.
// - On/off bit 7 turns output on; bits 6-4 zero; 3-0 ignored.
// - After reset the on/off control mirrors the enable pin.
// - Write protect 80h blocks all writes except write-protect itself.
module pmbus_target
  import pmbus_target_pkg::*;
#(
  parameter int PROG_OPEN_CYCLES = `PROG_OPEN_CYCLES,
  parameter int WORD_CODES = 7
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  // Serial bus pins
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic ALERT_B_O,
  // Strap, mode and enable
  input wire logic [4:0] ADDR_STRAP_PIN_I,
  input wire logic [1:0] BUS_MODE_I,
  input wire logic POWER_ENABLE_INPUT_I,
  input wire logic ALERT_REQ_I,
  // Telemetry words for 88h..8Eh
  input wire logic [WORD_CODES*16-1:0] TELEMETRY_I,
  // Regulator side
  output logic OUTPUT_ON_O,
  output logic SOFT_START_O,
  output logic PROG_WINDOW_O,
  output logic CFG_WRITE_O,
  output logic [7:0] CFG_CODE_O,
  output logic [7:0] CFG_DATA_O,
  output logic PEC_ERROR_O
);
  bus_state_t state_reg;
  logic scl_d_reg, sda_d_reg;
  logic [7:0] own_addr8_reg;
  logic [7:0] shift_reg, cmd_reg, wdata_reg, tx_reg, crc_reg;
  logic [3:0] bit_cnt_reg;
  logic [2:0] byte_cnt_reg;
  logic [7:0] crc_next;
  logic [7:0] on_off_reg, wp_reg, user_f2_reg, vin_mode_reg;
  logic reading_reg, ara_reg, strap_done_reg, on_off_touched_reg;
  logic [31:0] open_cnt_reg;
  logic window_open, start_det, stop_det, scl_rise, scl_fall;
  logic smb_mode, is_word, is_rd_cmd, wr_ok;
  logic [2:0] word_idx;
  logic [15:0] word_val;
  logic [7:0] rd_len;

  assign start_det = scl_d_reg && SCL_I && sda_d_reg && !SDA_I;
  assign stop_det = scl_d_reg && SCL_I && !sda_d_reg && SDA_I;
  assign scl_rise = !scl_d_reg && SCL_I;
  assign scl_fall = scl_d_reg && !SCL_I;
  assign smb_mode = (BUS_MODE_I != MODE_I2C);
  assign is_word = (cmd_reg >= `CMD_WORD_LO) &&
                   (cmd_reg <= `CMD_WORD_HI);
  assign word_idx = 3'(cmd_reg - `CMD_WORD_LO);
  assign word_val = TELEMETRY_I[word_idx*16 +: 16];
  assign rd_len = is_word ? 8'h02 : 8'h01;
  assign is_rd_cmd = !ara_reg;
  assign window_open = (open_cnt_reg >= 32'(PROG_OPEN_CYCLES)) &&
                       !POWER_ENABLE_INPUT_I;
  // Commit gate: write protect, window-only codes, reserved on/off bits
  assign wr_ok = ((wp_reg != `WP_ALL) ||
                  (cmd_reg == `CMD_WRITE_PROTECT)) &&
                 (window_open || ((cmd_reg != `CMD_VIN_MODE) &&
                                  (cmd_reg != `CMD_USER_F2))) &&
                 !((cmd_reg == `CMD_ON_OFF_CONTROL) &&
                   (wdata_reg[6:4] != 3'h0));

  pec_crc8 u_crc (
    .crc_i(crc_reg),
    .data_i(shift_reg),
    .crc_o(crc_next)
  );

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= SCL_I;
      sda_d_reg <= SDA_I;
    end
  end

  // Strap captured once after reset release
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      own_addr8_reg <= 8'h80;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      case (ADDR_STRAP_PIN_I[4:3])
        2'd0: own_addr8_reg <= {4'h8, ADDR_STRAP_PIN_I[2:0], 1'b0};
        2'd1: own_addr8_reg <= {4'hC, ADDR_STRAP_PIN_I[2:0], 1'b0};
        2'd2: own_addr8_reg <= {4'hE, ADDR_STRAP_PIN_I[2:0], 1'b0};
        default: own_addr8_reg <= {4'hF, ADDR_STRAP_PIN_I[2:0], 1'b0};
      endcase
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      open_cnt_reg <= 32'h0;
      SOFT_START_O <= 1'b0;
      PROG_WINDOW_O <= 1'b0;
    end else begin
      if (open_cnt_reg < 32'(PROG_OPEN_CYCLES)) begin
        open_cnt_reg <= open_cnt_reg + 32'h1;
      end
      PROG_WINDOW_O <= window_open;
      // Soft-start no earlier than the load delay after reset
      SOFT_START_O <= (open_cnt_reg >= 32'(PROG_OPEN_CYCLES)) &&
                      OUTPUT_ON_O;
    end
  end

  // Bus protocol engine
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 3'h0;
      cmd_reg <= 8'h00;
      wdata_reg <= 8'h00;
      tx_reg <= 8'h00;
      crc_reg <= 8'h00;
      reading_reg <= 1'b0;
      ara_reg <= 1'b0;
      SDA_O <= 1'b0;
      SDA_OE_O <= 1'b0;
      CFG_WRITE_O <= 1'b0;
      CFG_CODE_O <= 8'h00;
      CFG_DATA_O <= 8'h00;
      PEC_ERROR_O <= 1'b0;
    end else begin
      CFG_WRITE_O <= 1'b0;
      PEC_ERROR_O <= 1'b0;
      if (start_det) begin
        // Repeated start keeps the command byte for the read
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        SDA_OE_O <= 1'b0;
        if (state_reg == ST_IDLE) begin
          crc_reg <= 8'h00;
          byte_cnt_reg <= 3'h0;
        end
      end else if (stop_det) begin
        // Single data byte with no PEC commits at stop
        if (state_reg != ST_IGNORE && !reading_reg && !ara_reg &&
            byte_cnt_reg == 3'h2 && wr_ok) begin
          CFG_WRITE_O <= 1'b1;
          CFG_CODE_O <= cmd_reg;
          CFG_DATA_O <= wdata_reg;
        end
        state_reg <= ST_IDLE;
        SDA_OE_O <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], SDA_I};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == 4'h8) begin
              bit_cnt_reg <= 4'h0;
              crc_reg <= crc_next;
              if (state_reg == ST_ADDR) begin
                reading_reg <= (shift_reg[0] == `DIR_READ);
                if (shift_reg[7:1] == own_addr8_reg[7:1]) begin
                  ara_reg <= 1'b0;
                  state_reg <= ST_ADDR_ACK;
                  SDA_O <= 1'b0;
                  SDA_OE_O <= 1'b1;
                end else if (smb_mode && shift_reg ==
                             `ALERT_RESP_ADDR8) begin
                  ara_reg <= 1'b1;
                  state_reg <= ST_ADDR_ACK;
                  SDA_O <= 1'b0;
                  SDA_OE_O <= 1'b1;
                end else begin
                  state_reg <= ST_IGNORE;
                end
              end else begin
                if (byte_cnt_reg == 3'h0) begin
                  cmd_reg <= shift_reg;
                end else if (byte_cnt_reg == 3'h1) begin
                  wdata_reg <= shift_reg;
                end else if (smb_mode && byte_cnt_reg == 3'h2) begin
                  // Trailing PEC byte checks the write
                  if (crc_reg != shift_reg) begin
                    PEC_ERROR_O <= 1'b1;
                  end else if (wr_ok) begin
                    CFG_WRITE_O <= 1'b1;
                    CFG_CODE_O <= cmd_reg;
                    CFG_DATA_O <= wdata_reg;
                  end
                  byte_cnt_reg <= 3'h4;
                end
                if (byte_cnt_reg < 3'h2) begin
                  byte_cnt_reg <= byte_cnt_reg + 3'h1;
                end
                state_reg <= ST_RX_ACK;
                SDA_O <= 1'b0;
                SDA_OE_O <= 1'b1;
              end
            end
          end
          ST_ADDR_ACK, ST_RX_ACK: begin
            if (scl_fall) begin
              SDA_OE_O <= 1'b0;
              if (state_reg == ST_ADDR_ACK && reading_reg) begin
                byte_cnt_reg <= 3'h0;
                if (ara_reg) begin
                  tx_reg <= own_addr8_reg;
                end else if (is_word) begin
                  tx_reg <= word_val[7:0];
                end else if (cmd_reg == `CMD_ON_OFF_CONTROL) begin
                  tx_reg <= on_off_reg;
                end else if (cmd_reg == `CMD_WRITE_PROTECT) begin
                  tx_reg <= wp_reg;
                end else if (cmd_reg == `CMD_USER_F2) begin
                  tx_reg <= user_f2_reg;
                end else begin
                  tx_reg <= vin_mode_reg;
                end
                state_reg <= ST_TX;
                SDA_OE_O <= 1'b1;
                SDA_O <= 1'b0;
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            SDA_OE_O <= !tx_reg[7];
            SDA_O <= 1'b0;
            if (scl_fall) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == 4'h7) begin
                state_reg <= ST_TX_ACK;
                SDA_OE_O <= 1'b0;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
              end
            end
            if (scl_rise && bit_cnt_reg == 4'h0) begin
              shift_reg <= tx_reg;
            end
          end
          ST_TX_ACK: begin
            if (scl_rise && SDA_I) begin
              state_reg <= ST_IGNORE;
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              byte_cnt_reg <= byte_cnt_reg + 3'h1;
              crc_reg <= crc_next;
              state_reg <= ST_TX;
              if (!ara_reg && byte_cnt_reg == 3'h0 && is_word) begin
                tx_reg <= word_val[15:8];
              end else if (smb_mode &&
                           {5'h0, byte_cnt_reg} == rd_len - 8'h1 &&
                           is_rd_cmd) begin
                tx_reg <= crc_next;
              end else begin
                tx_reg <= 8'hFF;
              end
            end
          end
          ST_IDLE, ST_IGNORE: begin
            SDA_OE_O <= 1'b0;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Configuration registers
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      on_off_reg <= 8'h00;
      on_off_touched_reg <= 1'b0;
      wp_reg <= `WP_RESET;
      user_f2_reg <= 8'h00;
      vin_mode_reg <= 8'h00;
    end else begin
      if (!on_off_touched_reg) begin
        on_off_reg <= {POWER_ENABLE_INPUT_I, 7'h00};
      end
      if (CFG_WRITE_O) begin
        case (CFG_CODE_O)
          `CMD_ON_OFF_CONTROL: begin
            if (CFG_DATA_O[6:4] == 3'h0) begin
              on_off_reg <= {CFG_DATA_O[7], 7'h00};
              on_off_touched_reg <= 1'b1;
            end
          end
          `CMD_WRITE_PROTECT: wp_reg <= CFG_DATA_O;
          `CMD_USER_F2: if (window_open) user_f2_reg <= CFG_DATA_O;
          `CMD_VIN_MODE: if (window_open) vin_mode_reg <= CFG_DATA_O;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      OUTPUT_ON_O <= 1'b0;
      ALERT_B_O <= 1'b1;
    end else begin
      OUTPUT_ON_O <= on_off_reg[`ON_OFF_RUN_BIT];
      ALERT_B_O <= !(smb_mode && ALERT_REQ_I);
    end
  end
endmodule

/* dv/pmbus_target_checker.sv */
// Port assertions for the serial management target
`timescale 1ns/1ps
module pmbus_target_checker
  import pmbus_target_pkg::*;
#(
  parameter int PROG_OPEN_CYCLES = 50
) (
  // Clock, reset and bus
  input wire logic CLOCK_I,
  input wire logic RST_B_I,
  input wire logic SCL_I,
  input wire logic SDA_OE_O,
  input wire logic ALERT_B_O,
  // Mode and enable
  input wire logic [1:0] BUS_MODE_I,
  input wire logic POWER_ENABLE_INPUT_I,
  input wire logic ALERT_REQ_I,
  // Regulator side
  input wire logic OUTPUT_ON_O,
  input wire logic SOFT_START_O,
  input wire logic PROG_WINDOW_O,
  input wire logic CFG_WRITE_O,
  input wire logic [7:0] CFG_CODE_O,
  input wire logic [7:0] CFG_DATA_O,
  input wire logic PEC_ERROR_O
);
  int cnt_reg;
  // Cycles since reset release, saturating
  always_ff @(posedge CLOCK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      cnt_reg <= 0;
    end else if (cnt_reg < PROG_OPEN_CYCLES) begin
      cnt_reg <= cnt_reg + 1;
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_B_I);
  sequence en_held;
    POWER_ENABLE_INPUT_I ##1 POWER_ENABLE_INPUT_I;
  endsequence
  sequence onoff_write;
    CFG_WRITE_O && CFG_CODE_O == 8'h01;
  endsequence
  a_win_time: assert property (
    PROG_WINDOW_O |-> cnt_reg >= PROG_OPEN_CYCLES - 1)
    else $error("window open too early");
  a_win_shut: assert property (
    en_held |-> !PROG_WINDOW_O)
    else $error("window open with enable high");
  a_cfg_single: assert property (
    CFG_WRITE_O |=> !CFG_WRITE_O)
    else $error("write pulse too long");
  a_cfg_window: assert property (
    CFG_WRITE_O && (CFG_CODE_O == 8'h78 || CFG_CODE_O == 8'hF2)
    |-> PROG_WINDOW_O)
    else $error("config write outside window");
  a_onoff_field: assert property (
    onoff_write |-> CFG_DATA_O[6:4] == 3'h0)
    else $error("on/off write with reserved bits");
  a_onoff_apply: assert property (
    onoff_write |-> ##[0:2] OUTPUT_ON_O == CFG_DATA_O[7])
    else $error("output state not applied");
  a_ss_timing: assert property (
    SOFT_START_O |-> cnt_reg >= PROG_OPEN_CYCLES - 1
    && (OUTPUT_ON_O || $past(OUTPUT_ON_O)))
    else $error("soft start out of order");
  a_pec_single: assert property (
    PEC_ERROR_O |=> !PEC_ERROR_O)
    else $error("check error pulse too long");
  a_oe_scl_low: assert property (
    $changed(SDA_OE_O) |-> !SCL_I)
    else $error("data line changed with clock high");
  a_alert_level: assert property (
    1'b1 |=> ALERT_B_O ==
    !($past(BUS_MODE_I) != MODE_I2C && $past(ALERT_REQ_I)))
    else $error("alert level wrong");
endmodule

/* dv/pmbus_host_model.sv */
// Behavioural bus host driving clock and data with a pull-up
`timescale 1ns/1ps
module pmbus_host_model (
  // Clock
  input wire logic clk_i,
  // Target data driver
  input wire logic sda_oe_i,
  input wire logic sda_i,
  // Bus lines
  output logic scl_o,
  output logic sda_o
);
  logic pull_low = 1'b0;
  initial scl_o = 1'b1;
  // Wired-and with pull-up
  assign sda_o = !(pull_low || (sda_oe_i && !sda_i));
  task automatic wait4();
    repeat (4) @(negedge clk_i);
  endtask
  // Used for both start and repeated start, including right after a stop
  task automatic start();
    pull_low = 1'b0;
    wait4();
    scl_o = 1'b1;
    wait4();
    pull_low = 1'b1;
    wait4();
    scl_o = 1'b0;
  endtask
  task automatic stop();
    pull_low = 1'b1;
    wait4();
    scl_o = 1'b1;
    wait4();
    pull_low = 1'b0;
    wait4();
  endtask
  task automatic bit_io(input logic b, output logic s);
    pull_low = !b;
    wait4();
    scl_o = 1'b1;
    wait4();
    s = sda_o;
    scl_o = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack,
                         output logic [7:0] q, output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ack, ack_seen);
  endtask
endmodule

/* dv/pmbus_target_bench.sv */
// Self-checking bench for the serial management target
`timescale 1ns/1ps
module pmbus_target_bench
  import pmbus_target_pkg::*;
;
  localparam int PROG = 2000;
  typedef struct {
    logic [4:0] strap;
    bus_mode_t mode;
    logic [7:0] addr;
    logic [7:0] code;
  } row_t;
  row_t rows [4] = '{
    '{5'h00, MODE_I2C, 8'h80, 8'h88},
    '{5'h0F, MODE_SMBUS, 8'hCE, 8'h8A},
    '{5'h12, MODE_PMBUS, 8'hE4, 8'h8E},
    '{5'h1F, MODE_SMBUS, 8'hFE, 8'h8C}
  };
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] strap = 5'h00;
  bus_mode_t mode = MODE_SMBUS;
  logic en = 1'b0;
  logic alert_req = 1'b1;
  logic [111:0] telem = 112'hB6A6_B5A5_B4A4_B3A3_B2A2_B1A1_B0A0;
  logic scl, sda, sda_o, sda_oe, alert_b, out_on, ss, win, cfg_w, pec_err;
  logic [7:0] cfg_code, cfg_data, q;
  logic [15:0] last_cfg, w;
  logic k;
  int checks = 0, err_total = 0, wr_cnt = 0, pec_cnt = 0;
  always #20 clk = ~clk;
  pmbus_target #(.PROG_OPEN_CYCLES(PROG)) dut (
    .CLOCK_I(clk), .RST_B_I(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE_O(sda_oe), .ALERT_B_O(alert_b),
    .ADDR_STRAP_PIN_I(strap), .BUS_MODE_I(mode),
    .POWER_ENABLE_INPUT_I(en), .ALERT_REQ_I(alert_req),
    .TELEMETRY_I(telem), .OUTPUT_ON_O(out_on), .SOFT_START_O(ss),
    .PROG_WINDOW_O(win), .CFG_WRITE_O(cfg_w), .CFG_CODE_O(cfg_code),
    .CFG_DATA_O(cfg_data), .PEC_ERROR_O(pec_err));
  pmbus_host_model host (.clk_i(clk), .sda_oe_i(sda_oe), .sda_i(sda_o),
    .scl_o(scl), .sda_o(sda));
  always @(negedge clk) begin
    if (cfg_w) begin
      wr_cnt++;
      last_cfg = {cfg_code, cfg_data};
    end
    if (pec_err) pec_cnt++;
  end
  task automatic check(input string n, input logic [15:0] e, s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? (r << 1) ^ 8'h07 : r << 1;
    return r;
  endfunction
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask
  task automatic wait_win();
    for (int i = 0; i < PROG + 50 && win !== 1'b1; i++) @(negedge clk);
    check("window", 1, win);
    if (win !== 1'b1) summarize();
  endtask
  // One command per address in each frame
  task automatic wr(input logic [7:0] a, c, d, input logic bad);
    logic [7:0] p;
    p = crc(crc(crc(8'h00, a), c), d) ^ {7'h0, bad};
    host.start();
    host.byte_io(a, 1'b1, q, k);
    host.byte_io(c, 1'b1, q, k);
    host.byte_io(d, 1'b1, q, k);
    if (mode != MODE_I2C) host.byte_io(p, 1'b1, q, k);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] a, c, input int n);
    logic [7:0] p;
    logic ak;
    w = 16'h0000;
    p = crc(crc(crc(8'h00, a), c), a | 8'h01);
    host.start();
    host.byte_io(a, 1'b1, q, ak);
    host.byte_io(c, 1'b1, q, k);
    host.start();
    host.byte_io(a | 8'h01, 1'b1, q, k);
    for (int i = 0; i < n; i++) begin
      host.byte_io(8'hFF, i == n - 1 && mode == MODE_I2C, q, k);
      w[i*8+:8] = q;
      p = crc(p, q);
    end
    if (mode != MODE_I2C) begin
      host.byte_io(8'hFF, 1'b1, q, k);
      check("pec", p, q);
    end
    host.stop();
    check("ack", 0, ak);
  endtask
  task automatic ara();
    host.start();
    host.byte_io(8'h19, 1'b1, q, k);
    host.byte_io(8'hFF, 1'b1, w[7:0], w[8]);
    host.stop();
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    foreach (rows[r]) begin
      @(negedge clk);
      strap = rows[r].strap;
      mode = rows[r].mode;
      do_reset();
      rd(rows[r].addr, rows[r].code, 2);
      check("word", telem[(rows[r].code - 8'h88) * 16 +: 16], w);
      check("alert", mode == MODE_I2C, alert_b);
      host.start();
      host.byte_io(rows[r].addr ^ 8'h02, 1'b1, q, k);
      host.stop();
      check("foreign nack", 1, k);
      $display("row %0d done", r);
    end
    mode = MODE_SMBUS;
    strap = 5'h00;
    do_reset();
    wr_cnt = 0;
    pec_cnt = 0;
    check("follows enable", 0, out_on);
    wr(8'h80, 8'h78, 8'h5A, 1'b0);
    check("early write", 0, wr_cnt);
    wait_win();
    wr(8'h80, 8'h78, 8'h5A, 1'b0);
    check("cfg write", 16'h785A, last_cfg);
    rd(8'h80, 8'h78, 1);
    check("byte read", 16'h005A, w);
    wr(8'h80, 8'hF2, 8'h33, 1'b1);
    check("bad pec", 1, pec_cnt);
    check("no commit", 1, wr_cnt);
    $display("window test done");
    wr(8'h80, 8'h01, 8'h90, 1'b0);
    check("reserved bits", 0, out_on);
    wr(8'h80, 8'h01, 8'h8F, 1'b0);
    check("turn on", 1, out_on);
    check("soft start", 1, ss);
    wr(8'h80, 8'h10, 8'h80, 1'b0);
    wr(8'h80, 8'h01, 8'h00, 1'b0);
    check("protected", 1, out_on);
    wr(8'h80, 8'h10, 8'h00, 1'b0);
    wr(8'h80, 8'h01, 8'h00, 1'b0);
    check("turn off", 0, out_on);
    ara();
    check("ara addr", 16'h0080, {7'h0, k, w[7:0]});
    mode = MODE_I2C;
    ara();
    check("ara i2c", 1, k);
    wr(8'h80, 8'hF2, 8'h44, 1'b0);
    check("i2c write", 16'hF244, last_cfg);
    rd(8'h80, 8'hF2, 1);
    check("i2c byte read", 16'h0044, w);
    $display("command test done");
    en = 1'b1;
    repeat (3) @(negedge clk);
    check("window shut", 0, win);
    do_reset();
    check("on at reset", 1, out_on);
    check("wait start", 0, ss);
    repeat (PROG + 5) @(negedge clk);
    check("late start", 1, ss);
    $display("power test done");
    summarize();
  end
endmodule
bind pmbus_target pmbus_target_checker
  #(.PROG_OPEN_CYCLES(PROG_OPEN_CYCLES)) u_chk (.*);
